/* File: sbu_defs.svh */
`ifndef SBU_DEFS_SVH
`define SBU_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define SBU_ADDR_CONTROL 16'h7fe8
`define SBU_ADDR_BUS_STATUS 16'h7fe9
`define SBU_ADDR_PORT_CONTROL 16'h7fea
`define SBU_ADDR_DATA_BUFFER 16'h7feb
`define SBU_RESET_VALUE 8'h00
`define SBU_IRQ_VECTOR 16'h801c

// ****************************************
// slave_control fields
// ****************************************
`define SBU_BIT_RUN 7
`define SBU_BIT_TRANSMIT_SELECT 6
`define SBU_BIT_ALWAYS_SELECTED 5
`define SBU_BIT_EIGHTH_CLOCK_EN 4
`define SBU_BIT_STOP_FLAG 3
`define SBU_BIT_STOP_IRQ_EN 2
`define SBU_BIT_TRANSFER_FLAG 1
`define SBU_BIT_TRANSFER_IRQ_EN 0

// ****************************************
// slave_bus_status fields
// ****************************************
`define SBU_BIT_ACK_RECEIVED 7
`define SBU_BIT_ACK_DRIVE 6
`define SBU_BIT_ADDRESS_MATCH 5
`define SBU_BIT_GENERAL_CALL 4
`define SBU_BIT_START_SEEN 3
`define SBU_BIT_RESTART_SEEN 2
`define SBU_BIT_ACK_CLOCK_PHASE 1
`define SBU_BIT_BUS_BUSY 0
`define SBU_SYNC_STATUS_MASK 8'h40

// ****************************************
// slave_port_control and address setting fields
// ****************************************
`define SBU_BIT_SERIAL_MODE 6
`define SBU_BIT_FILTER_HI 5
`define SBU_BIT_FILTER_LO 4
`define SBU_BIT_COMPARE_DISABLE 7

// ****************************************
// bit counts
// ****************************************
`define SBU_RISE_EIGHTH 4'h8
`define SBU_RISE_ACK 4'h9
`define SBU_SYNC_LAST_RISE 4'h7

`endif

/* File: sbu_pkg.sv */
package sbu_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbu_bus_req_type;

  typedef enum logic [1:0] {
    sbu_idle,
    sbu_addr,
    sbu_data,
    sbu_skip
  } sbu_state_type;

endpackage : sbu_pkg

/* File: sbu_pin_sync.sv */
`timescale 1ns/100ps

module sbu_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic filter_on,
  input wire logic [1:0] filter_len,
  output logic level
);

  logic s1, s2, s3;
  logic [1:0] cnt;
  logic next_level;
  logic [1:0] next_cnt;

  // ****************************************
  // agreement of the last two stages, optional glitch filter
  // ****************************************
  always_comb begin
    next_level = level;
    next_cnt = 2'h0;
    if ((s2 == s3) && (s3 != level)) begin
      if (!filter_on || (cnt == filter_len)) begin
        next_level = s3;
      end else begin
        next_cnt = cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
      cnt <= 2'h0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      cnt <= next_cnt;
    end
  end

endmodule : sbu_pin_sync

/* File: sbu_slave.sv */
`timescale 1ns/100ps
`include "sbu_defs.svh"

// Functional notes
// [R1] offers slave i2c mode and an 8-bit msb-first synchronous serial port
// [R2] the far master supplies every serial clock; this block never drives one
// [R3] i2c mode with run low: data buffer address reaches the slave address register
// [R4] run bit 7 of control starts the unit at 1, stops it at 0
// [R5] i2c transmit_select 1 transmits; cleared on start, stop or high acknowledge
// [R6] serial mode transmit_select 1 sends data, 0 receives data
// [R7] always_selected 1 sets transfer_flag every byte, else address_match_flag decides
// [R8] software keeps always_selected and eighth_clock_flag_enable at 0 in serial mode
// [R9] i2c stop condition sets stop_flag, cleared only by a software write
// [R10] serial mode: clock falling edge while transfer_flag set sets stop_flag
// [R11] stop_irq_enable and stop_flag both 1 raise the interrupt request
// [R12] transfer_irq_enable and transfer_flag both 1 raise the interrupt request
// [R13] i2c transfer_flag never sets while address_match_flag and always_selected are 0
// [R14] flag at ack fall only, or also eighth fall when enabled or general call
// [R15] i2c: transfer_flag set and clock low holds clock low until software clears
// [R16] software clears transfer_flag only after loading or reading the data buffer
// [R17] software changes transmit_select or ack_drive_value only while transfer_flag is set
// [R18] serial mode: transfer_flag sets on the eighth clock rising edge, software clears
// [R19] serial_mode_select 1 gives serial mode without filter, 0 gives i2c with filter
// [R20] first byte upper seven bits equal to slave address set address_match_flag when comparison is enabled
// [R21] first byte all zero sets general_call_flag when comparison is enabled
// [R22] clearing run returns counter and state to idle and releases the clock

module sbu_slave (
  input wire logic core_clk,
  input wire logic rstn,
  input wire sbu_pkg::sbu_bus_req_type bus,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq_req,
  output logic [15:0] irq_vector
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_pipe;
  logic rst_n_i;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_i = rst_pipe[1];

  // ****************************************
  // pins
  // ****************************************
  logic [7:0] ctrl, stat, pcnt, data_buf, addr_set;
  logic scl_f, sda_f, scl_d, sda_d;
  logic i2c, serial_mode_select, run;

  assign serial_mode_select = pcnt[`SBU_BIT_SERIAL_MODE];
  assign i2c = ~serial_mode_select;
  assign run = ctrl[`SBU_BIT_RUN];

  // filter only in i2c mode; serial mode wants the shortest path [R19]
  sbu_pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .core_clk(core_clk),
    .rst_n(rst_n_i),
    .pin(scl_in),
    .filter_on(i2c),
    .filter_len(pcnt[`SBU_BIT_FILTER_HI:`SBU_BIT_FILTER_LO]),
    .level(scl_f)
  );

  sbu_pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .core_clk(core_clk),
    .rst_n(rst_n_i),
    .pin(sda_in),
    .filter_on(i2c),
    .filter_len(pcnt[`SBU_BIT_FILTER_HI:`SBU_BIT_FILTER_LO]),
    .level(sda_f)
  );

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_det = i2c & scl_f & scl_d & sda_d & ~sda_f;
  assign stop_det = i2c & scl_f & scl_d & ~sda_d & sda_f;

  // ****************************************
  // bus protocol and registers
  // ****************************************
  sbu_pkg::sbu_state_type state, next_state;
  logic [3:0] rise_cnt, next_rise_cnt;
  logic first_byte, next_first_byte, ack_phase, next_ack_phase;
  logic rx_bit, next_rx_bit, scl_hold, next_scl_hold;
  logic next_sda_oe, next_sda_out, next_irq;
  logic [7:0] next_ctrl, next_stat, next_pcnt, next_data_buf, next_addr_set, next_rdata;
  logic [7:0] rx_byte;
  logic gcall, match, sel;

  always_comb begin
    next_ctrl = ctrl;
    next_stat = stat;
    next_pcnt = pcnt;
    next_data_buf = data_buf;
    next_addr_set = addr_set;
    next_state = state;
    next_rise_cnt = rise_cnt;
    next_first_byte = first_byte;
    next_ack_phase = ack_phase;
    next_rx_bit = rx_bit;
    rx_byte = {data_buf[6:0], rx_bit};
    gcall = ~addr_set[`SBU_BIT_COMPARE_DISABLE] & (rx_byte == 8'h00); // [R21]
    match = ~addr_set[`SBU_BIT_COMPARE_DISABLE] & ((rx_byte[7:1] == addr_set[6:0]) | gcall); // [R20]
    sel = stat[`SBU_BIT_ADDRESS_MATCH] | ctrl[`SBU_BIT_ALWAYS_SELECTED];
    // software writes; flags only clear, so writing 1 leaves them alone
    if (bus.wr) begin
      unique case (bus.addr)
        `SBU_ADDR_CONTROL: begin
          next_ctrl = bus.wdata;
          next_ctrl[`SBU_BIT_STOP_FLAG] = bus.wdata[`SBU_BIT_STOP_FLAG] & ctrl[`SBU_BIT_STOP_FLAG]; // [R9]
          next_ctrl[`SBU_BIT_TRANSFER_FLAG] = bus.wdata[`SBU_BIT_TRANSFER_FLAG] & ctrl[`SBU_BIT_TRANSFER_FLAG];
          if (ctrl[`SBU_BIT_TRANSFER_FLAG] & ~bus.wdata[`SBU_BIT_TRANSFER_FLAG]) begin
            next_stat[`SBU_BIT_START_SEEN] = 1'b0;
            next_stat[`SBU_BIT_RESTART_SEEN] = 1'b0;
          end
        end
        `SBU_ADDR_BUS_STATUS: next_stat[`SBU_BIT_ACK_DRIVE] = bus.wdata[`SBU_BIT_ACK_DRIVE];
        `SBU_ADDR_PORT_CONTROL: next_pcnt = bus.wdata;
        `SBU_ADDR_DATA_BUFFER: begin
          if (i2c & ~run) begin
            next_addr_set = bus.wdata; // [R3]
          end else begin
            next_data_buf = bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    // hardware events come after the writes so a set beats a clear
    if (!run) begin
      next_state = sbu_pkg::sbu_idle; // [R4] [R22]
      next_rise_cnt = 4'h0;
      next_first_byte = 1'b0;
      next_ack_phase = 1'b0;
      next_stat = next_stat & `SBU_SYNC_STATUS_MASK;
    end else if (serial_mode_select) begin
      if (scl_rise) begin
        next_data_buf = {next_data_buf[6:0], sda_f}; // [R1]
        next_rise_cnt = rise_cnt + 4'h1;
        if (rise_cnt == `SBU_SYNC_LAST_RISE) begin
          next_ctrl[`SBU_BIT_TRANSFER_FLAG] = 1'b1; // [R18]
          next_rise_cnt = 4'h0;
        end
      end
      if (scl_fall & ctrl[`SBU_BIT_TRANSFER_FLAG]) begin
        next_ctrl[`SBU_BIT_STOP_FLAG] = 1'b1; // [R10]
      end
    end else if (start_det) begin
      next_stat[`SBU_BIT_RESTART_SEEN] = stat[`SBU_BIT_BUS_BUSY];
      next_stat[`SBU_BIT_START_SEEN] = 1'b1;
      next_stat[`SBU_BIT_BUS_BUSY] = 1'b1;
      next_stat[`SBU_BIT_ADDRESS_MATCH] = 1'b0;
      next_stat[`SBU_BIT_GENERAL_CALL] = 1'b0;
      next_stat[`SBU_BIT_ACK_DRIVE] = 1'b1;
      next_stat[`SBU_BIT_ACK_CLOCK_PHASE] = 1'b0;
      next_ctrl[`SBU_BIT_TRANSMIT_SELECT] = 1'b0; // [R5]
      next_state = sbu_pkg::sbu_addr;
      next_rise_cnt = 4'h0;
      next_first_byte = 1'b1;
      next_ack_phase = 1'b0;
    end else if (stop_det) begin
      next_ctrl[`SBU_BIT_STOP_FLAG] = 1'b1; // [R9]
      next_ctrl[`SBU_BIT_TRANSMIT_SELECT] = 1'b0; // [R5]
      next_stat = next_stat & `SBU_SYNC_STATUS_MASK;
      next_stat[`SBU_BIT_ACK_RECEIVED] = stat[`SBU_BIT_ACK_RECEIVED];
      next_stat[`SBU_BIT_ACK_DRIVE] = 1'b1;
      next_state = sbu_pkg::sbu_idle;
      next_rise_cnt = 4'h0;
      next_first_byte = 1'b0;
      next_ack_phase = 1'b0;
    end else if (state != sbu_pkg::sbu_idle) begin
      if (scl_rise) begin
        next_rx_bit = sda_f;
        if (rise_cnt != `SBU_RISE_ACK) begin
          next_rise_cnt = rise_cnt + 4'h1;
        end
        if (rise_cnt == `SBU_RISE_EIGHTH) begin
          next_stat[`SBU_BIT_ACK_RECEIVED] = sda_f;
          if (sda_f & ctrl[`SBU_BIT_TRANSMIT_SELECT]) begin
            next_ctrl[`SBU_BIT_TRANSMIT_SELECT] = 1'b0; // [R5]
            next_stat[`SBU_BIT_ACK_DRIVE] = 1'b1;
          end
        end
      end
      if (scl_fall) begin
        next_stat[`SBU_BIT_ACK_CLOCK_PHASE] = 1'b0;
        if ((rise_cnt != 4'h0) && (rise_cnt <= `SBU_RISE_EIGHTH) && (state != sbu_pkg::sbu_skip)) begin
          next_data_buf = rx_byte;
        end
        if (rise_cnt == `SBU_RISE_EIGHTH) begin
          next_ack_phase = 1'b1;
          if (state == sbu_pkg::sbu_addr) begin
            next_stat[`SBU_BIT_ADDRESS_MATCH] = match;
            next_stat[`SBU_BIT_GENERAL_CALL] = gcall;
            if (match | ctrl[`SBU_BIT_ALWAYS_SELECTED]) begin
              next_state = sbu_pkg::sbu_data;
              if (ctrl[`SBU_BIT_EIGHTH_CLOCK_EN] | gcall) begin
                next_ctrl[`SBU_BIT_TRANSFER_FLAG] = 1'b1; // [R14]
              end
            end else begin
              // unaddressed: sit out until the next start or stop [R13]
              next_state = sbu_pkg::sbu_skip;
              next_stat[`SBU_BIT_START_SEEN] = 1'b0;
              next_stat[`SBU_BIT_RESTART_SEEN] = 1'b0;
            end
          end else if ((state == sbu_pkg::sbu_data) & sel &
                       (ctrl[`SBU_BIT_EIGHTH_CLOCK_EN] | stat[`SBU_BIT_GENERAL_CALL])) begin
            next_ctrl[`SBU_BIT_TRANSFER_FLAG] = 1'b1; // [R7] [R14]
          end
        end
        if (rise_cnt == `SBU_RISE_ACK) begin
          next_ack_phase = 1'b0;
          next_rise_cnt = 4'h0;
          next_first_byte = 1'b0;
          next_stat[`SBU_BIT_ACK_CLOCK_PHASE] = 1'b1;
          if ((state == sbu_pkg::sbu_data) & sel) begin
            next_ctrl[`SBU_BIT_TRANSFER_FLAG] = 1'b1; // [R7] [R14]
          end
        end
      end
    end
    // stretch only while the clock is already low; never drive it high [R2] [R15]
    next_scl_hold = run & i2c & ctrl[`SBU_BIT_TRANSFER_FLAG] & (scl_hold | ~scl_f);
    // sda is open drain in i2c mode, push-pull in serial mode
    next_sda_out = 1'b0;
    next_sda_oe = 1'b0;
    if (run & serial_mode_select) begin
      next_sda_out = data_buf[7];
      next_sda_oe = ctrl[`SBU_BIT_TRANSMIT_SELECT]; // [R6]
    end else if (run & (state == sbu_pkg::sbu_data)) begin
      if (ack_phase) begin
        if (~ctrl[`SBU_BIT_TRANSMIT_SELECT]) begin
          next_sda_oe = (first_byte & stat[`SBU_BIT_ADDRESS_MATCH] & ~stat[`SBU_BIT_GENERAL_CALL]) |
                        ~stat[`SBU_BIT_ACK_DRIVE];
        end
      end else if (~first_byte) begin
        next_sda_oe = ctrl[`SBU_BIT_TRANSMIT_SELECT] & ~data_buf[7]; // [R5]
      end
    end
    next_irq = (ctrl[`SBU_BIT_STOP_IRQ_EN] & ctrl[`SBU_BIT_STOP_FLAG]) | // [R11]
               (ctrl[`SBU_BIT_TRANSFER_IRQ_EN] & ctrl[`SBU_BIT_TRANSFER_FLAG]); // [R12]
    // read data stand one cycle; status fields other than ack_drive_value read zero in serial mode
    next_rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `SBU_ADDR_CONTROL: next_rdata = ctrl;
        `SBU_ADDR_BUS_STATUS: next_rdata = serial_mode_select ? (stat & `SBU_SYNC_STATUS_MASK) : stat;
        `SBU_ADDR_PORT_CONTROL: next_rdata = pcnt;
        `SBU_ADDR_DATA_BUFFER: next_rdata = (i2c & ~run) ? addr_set : data_buf; // [R3]
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `SBU_RESET_VALUE;
      stat <= `SBU_RESET_VALUE;
      pcnt <= `SBU_RESET_VALUE;
      data_buf <= `SBU_RESET_VALUE;
      addr_set <= `SBU_RESET_VALUE;
      state <= sbu_pkg::sbu_idle;
      rise_cnt <= 4'h0;
      first_byte <= 1'b0;
      ack_phase <= 1'b0;
      rx_bit <= 1'b0;
      scl_hold <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      irq_req <= 1'b0;
      rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      pcnt <= next_pcnt;
      data_buf <= next_data_buf;
      addr_set <= next_addr_set;
      state <= next_state;
      rise_cnt <= next_rise_cnt;
      first_byte <= next_first_byte;
      ack_phase <= next_ack_phase;
      rx_bit <= next_rx_bit;
      scl_hold <= next_scl_hold;
      scl_d <= scl_f;
      sda_d <= sda_f;
      sda_out <= next_sda_out;
      sda_oe <= next_sda_oe;
      irq_req <= next_irq;
      rdata <= next_rdata;
    end
  end

  assign scl_out = 1'b0;
  assign scl_oe = scl_hold;
  assign irq_vector = `SBU_IRQ_VECTOR;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_i);

  sequence s_sync_eighth;
    run && serial_mode_select && scl_rise && (rise_cnt == 4'h7);
  endsequence

  sequence s_ack_fall;
    run && i2c && !start_det && !stop_det && scl_fall && (rise_cnt == 4'h9) &&
    (state == sbu_pkg::sbu_data) && sel;
  endsequence

  AST_RUN_STOP: assert property (!run |=> (state == sbu_pkg::sbu_idle) && !scl_oe) // [R22]
    else $error("stopped unit not idle");
  AST_STRETCH: assert property (run && i2c && ctrl[1] && !scl_f |=> scl_oe) // [R15]
    else $error("clock not stretched");
  AST_RELEASE: assert property (!ctrl[1] |=> !scl_oe) // [R15]
    else $error("clock held without flag");
  AST_STOP_SET: assert property (run && stop_det |=> ctrl[3]) // [R9]
    else $error("stop not flagged");
  AST_STOP_STICKY: assert property (ctrl[3] && !(bus.wr && bus.addr == 16'h7fe8) |=> ctrl[3]) // [R9]
    else $error("stop flag lost");
  AST_IRQ: assert property (irq_req == $past((ctrl[2] & ctrl[3]) | (ctrl[0] & ctrl[1]))) // [R11]
    else $error("interrupt request wrong");
  AST_UNSELECTED: assert property ($rose(ctrl[1]) && i2c |-> stat[5] || ctrl[5]) // [R13]
    else $error("flag set while unselected");
  AST_SYNC_FLAG: assert property (s_sync_eighth |=> ctrl[1] && (rise_cnt == 4'h0)) // [R18]
    else $error("serial byte end not flagged");
  AST_ACK_FLAG: assert property (s_ack_fall |=> ctrl[1] ##1 scl_oe) // [R14]
    else $error("ack clock flag or stretch missing");
  AST_TRX_CLEAR: assert property (run && (start_det || stop_det) |=> !ctrl[6]) // [R5]
    else $error("transmit select not cleared");
  AST_ALIAS: assert property (bus.rd && bus.addr == 16'h7feb && i2c && !run |=> rdata == $past(addr_set)) // [R3]
    else $error("address register not aliased");

endmodule : sbu_slave

/* File: sbu_bus_master.sv */
`timescale 1ns/100ps

// ****************
// far-side bus master, i2c and serial clock source
// ****************
module sbu_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic m_scl,
  output logic m_sda
);
  // count of clock releases that timed out; the bench turns it into a mismatch
  int stuck = 0;

  // released lines go to the pull-up level, never hold an old value
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end

  // a held clock could hang us, so the wait is bounded
  task automatic rel_scl;
    int n;
    n = 0;
    m_scl = 1'b1;
    while (scl !== 1'b1 && n < 2000) begin
      #25;
      n++;
    end
    if (n >= 2000) begin
      stuck++;
    end
  endtask : rel_scl

  task automatic start_c;
    m_sda = 1'b1;
    rel_scl();
    #100 m_sda = 1'b0;
    #100 m_scl = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #50 m_sda = 1'b0;
    #100 rel_scl();
    #100 m_sda = 1'b1;
    #200;
  endtask : stop_c

  task automatic send_bits(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      #50 m_sda = d[i];
      #100 rel_scl();
      #100 m_scl = 1'b0;
    end
  endtask : send_bits

  task automatic get_bits(output logic [7:0] q);
    #50 m_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #100 rel_scl();
      #100 q[i] = sda;
      m_scl = 1'b0;
      #50;
    end
  endtask : get_bits

  task automatic ack_clk(input logic lvl, output logic seen);
    #50 m_sda = lvl;
    #100 rel_scl();
    #100 seen = sda;
    m_scl = 1'b0;
  endtask : ack_clk

  // serial mode: clock stands high between bytes
  task automatic ser_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      m_scl = 1'b0;
      m_sda = d[i];
      #100 q[i] = sda;
      m_scl = 1'b1;
      #100;
    end
    m_sda = 1'b1;
  endtask : ser_byte
endmodule : sbu_bus_master

/* File: testbench.sv */
`timescale 1ns/100ps
`include "sbu_defs.svh"

module testbench;
  localparam logic [15:0] ctl = `SBU_ADDR_CONTROL;
  localparam logic [15:0] sta = `SBU_ADDR_BUS_STATUS;
  localparam logic [15:0] pct = `SBU_ADDR_PORT_CONTROL;
  localparam logic [15:0] dba = `SBU_ADDR_DATA_BUFFER;
  logic core_clk;
  logic rstn;
  sbu_pkg::sbu_bus_req_type bus;
  logic [7:0] rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, irq_req;
  logic [15:0] irq_vector;
  logic m_scl, m_sda, scl_w, sda_w, a;
  logic [7:0] q;
  int n_errors = 0;
  int num_checks = 0;

  // ****************
  // wired lines and instances
  // ****************
  assign scl_w = m_scl & ~(scl_oe & ~scl_out);
  assign sda_w = m_sda & (sda_oe ? sda_out : 1'b1);

  sbu_slave dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .bus(bus),
    .rdata(rdata),
    .scl_in(scl_w),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .irq_req(irq_req),
    .irq_vector(irq_vector)
  );
  sbu_bus_master mst (
    .scl(scl_w),
    .sda(sda_w),
    .m_scl(m_scl),
    .m_sda(m_sda)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
    // keeps every later link event off a clock edge, so pin sampling never races
    #1;
  endtask : wr

  task automatic rdc(input string nm, input logic [15:0] ad, input logic [7:0] m, input logic [7:0] exp);
    @(posedge core_clk);
    bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 chk(nm, exp, rdata & m);
  endtask : rdc

  task automatic hold_chk(input logic exp);
    int n;
    n = 0;
    while (scl_oe !== exp && n < 60) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk("scl_oe", {7'h00, exp}, {7'h00, scl_oe});
  endtask : hold_chk

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rdc("control", ctl, 8'hff, 8'h00);
    rdc("status", sta, 8'hff, 8'h00);
    rdc("port", pct, 8'hff, 8'h00);
    rdc("buffer", dba, 8'hff, 8'h00);
    rdc("unmapped", 16'h7fec, 8'hff, 8'h00);
    chk("vector_hi", 8'h80, irq_vector[15:8]);
    chk("vector_lo", 8'h1c, irq_vector[7:0]);
    chk("scl_drive", 8'h00, {7'h00, scl_out});
    wr(dba, 8'h20);
    rdc("addr_reg", dba, 8'hff, 8'h20);
    wr(ctl, 8'h85);
    rdc("buffer_run", dba, 8'hff, 8'h00);
    $display("done regs");
  endtask : t_regs

  task automatic t_rx;
    mst.start_c();
    mst.send_bits(8'h40);
    mst.ack_clk(1'b1, a);
    chk("addr_ack", 8'h00, {7'h00, a});
    hold_chk(1'b1);
    rdc("match", sta, 8'h30, 8'h20);
    rdc("flag", ctl, 8'h0a, 8'h02);
    chk("irq", 8'h01, {7'h00, irq_req});
    repeat (40) @(posedge core_clk);
    chk("stretch", 8'h01, {7'h00, scl_oe});
    wr(ctl, 8'h85);
    hold_chk(1'b0);
    mst.send_bits(8'ha5);
    mst.ack_clk(1'b1, a);
    hold_chk(1'b1);
    rdc("rx_data", dba, 8'hff, 8'ha5);
    wr(ctl, 8'h85);
    mst.stop_c();
    rdc("stop", ctl, 8'h0a, 8'h08);
    chk("stop_irq", 8'h01, {7'h00, irq_req});
    wr(ctl, 8'h85);
    rdc("stop_clr", ctl, 8'h0a, 8'h00);
    $display("done rx");
  endtask : t_rx

  task automatic t_sel;
    mst.start_c();
    mst.send_bits(8'h42);
    mst.ack_clk(1'b1, a);
    chk("nack", 8'h01, {7'h00, a});
    repeat (20) @(posedge core_clk);
    rdc("no_flag", ctl, 8'h02, 8'h00);
    chk("no_hold", 8'h00, {7'h00, scl_oe});
    mst.stop_c();
    wr(ctl, 8'ha0);
    mst.start_c();
    mst.send_bits(8'h42);
    mst.ack_clk(1'b1, a);
    hold_chk(1'b1);
    chk("masked_irq", 8'h00, {7'h00, irq_req});
    wr(ctl, 8'h22);
    hold_chk(1'b0);
    rdc("flag_kept", ctl, 8'h82, 8'h02);
    wr(ctl, 8'h00);
    mst.stop_c();
    $display("done select");
  endtask : t_sel

  task automatic t_eighth;
    wr(ctl, 8'h90);
    mst.start_c();
    mst.send_bits(8'h40);
    hold_chk(1'b1);
    wr(ctl, 8'h90);
    mst.ack_clk(1'b1, a);
    chk("ack8", 8'h00, {7'h00, a});
    hold_chk(1'b1);
    wr(ctl, 8'h80);
    mst.stop_c();
    mst.start_c();
    mst.send_bits(8'h00);
    hold_chk(1'b1);
    rdc("gen_call", sta, 8'h30, 8'h30);
    wr(ctl, 8'h80);
    mst.ack_clk(1'b1, a);
    hold_chk(1'b1);
    wr(ctl, 8'h80);
    mst.stop_c();
    $display("done eighth");
  endtask : t_eighth

  task automatic t_tx;
    mst.start_c();
    mst.send_bits(8'h41);
    mst.ack_clk(1'b1, a);
    hold_chk(1'b1);
    wr(ctl, 8'hc2);
    wr(dba, 8'hc3);
    wr(ctl, 8'hc0);
    mst.get_bits(q);
    chk("tx_data", 8'hc3, q);
    mst.ack_clk(1'b1, a);
    hold_chk(1'b1);
    rdc("tsel_clr", ctl, 8'h40, 8'h00);
    wr(ctl, 8'h80);
    mst.stop_c();
    $display("done tx");
  endtask : t_tx

  task automatic t_ser;
    wr(pct, 8'h40);
    wr(ctl, 8'h80);
    mst.ser_byte(8'h96, q);
    repeat (20) @(posedge core_clk);
    rdc("ser_flag", ctl, 8'h0a, 8'h02);
    chk("ser_hold", 8'h00, {7'h00, scl_oe});
    rdc("ser_rx", dba, 8'hff, 8'h96);
    wr(ctl, 8'hc2);
    wr(dba, 8'h3c);
    mst.ser_byte(8'hff, q);
    chk("ser_tx", 8'h3c, q);
    repeat (20) @(posedge core_clk);
    rdc("ser_stop", ctl, 8'h0a, 8'h0a);
    wr(ctl, 8'h00);
    wr(pct, 8'h00);
    $display("done serial");
  endtask : t_ser

  initial begin
    rstn = 1'b0;
    bus = '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_rx();
    t_sel();
    t_eighth();
    t_tx();
    t_ser();
    chk("scl_release", 8'h00, {7'h00, mst.stuck != 0});
    final_report();
  end

  // all scenarios take well under a tenth of this span
  initial begin
    #1_000_000;
    n_errors++;
    $display("BAD watchdog expected done seen hang");
    final_report();
  end
endmodule : testbench
